// file: rtl/ccmc_pkg.sv
package ccmc_pkg;
  // ==================================================
  // register map
  localparam logic [3:0] ADDR_MODE_CTRL  = 4'h0;  // channel_mode_control
  localparam logic [3:0] ADDR_HOLD_LOW   = 4'h1;  // holding_low_byte
  localparam logic [3:0] ADDR_HOLD_HIGH  = 4'h2;  // holding high byte
  localparam logic [3:0] ADDR_FLAG       = 4'h3;  // flag register image
  localparam logic [3:0] ADDR_STATUS     = 4'h4;  // block state readback
  // ==================================================
  // field layout
  localparam int MODE_LSB      = 0;
  localparam int DUTY_LSB      = 4;
  localparam int FLAG_BIT      = 2;  // channel_irq_flag position
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_MASK  = 8'h3f;
  // ==================================================
  // mode encodings
  localparam logic [3:0] MODE_OFF      = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE = 4'h5;
  localparam logic [3:0] MODE_CAP_4    = 4'h6;
  localparam logic [3:0] MODE_CAP_16   = 4'h7;
  localparam logic [3:0] MODE_CMP_SET  = 4'h8;
  localparam logic [3:0] MODE_CMP_CLR  = 4'h9;
  localparam logic [3:0] MODE_CMP_SW   = 4'ha;
  localparam logic [3:0] MODE_CMP_SPEV = 4'hb;
  localparam logic [3:0] PRESC_LAST_4  = 4'h3;
  localparam logic [3:0] PRESC_LAST_16 = 4'hf;
  // ==================================================
  // one-hot operating class
  typedef enum logic [3:0] {
    CL_OFF = 4'b0001,
    CL_CAP = 4'b0010,
    CL_CMP = 4'b0100,
    CL_PWM = 4'b1000
  } ccmc_class_t;
endpackage : ccmc_pkg

// file: rtl/ccmc_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for the channel pin
module ccmc_sync
(
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_async,
  output logic      o_sync
);
  logic meta_ff;
  // ==================================================
  // two stages, first stage read only by second
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      meta_ff <= 1'b0;
      o_sync  <= 1'b0;
    end
    else
    begin
      meta_ff <= i_async;
      o_sync  <= meta_ff;
    end
  end
endmodule : ccmc_sync

// file: rtl/ccmc_top.sv
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
// What this block does
// - mode 0000 disables channel and resets its internal state
// - 0100 captures every falling edge, 0101 every rising edge
// - 0110 captures every 4th rising edge, 0111 every 16th
// - 1000 drives output high on compare match and sets flag
// - 1001 drives output low on compare match and sets flag
// - 1010 sets flag only on match, pin level untouched
// - 1011 sets flag, clears timer one, second channel starts conversion
// - 11xx is PWM; duty is low byte then two extra bits
// - capture copies full 16-bit timer count into both holding bytes
// - capture sets flag bit 2; hardware never clears it
// - a newer capture simply overwrites the older held value
// - edge detector watches pin level even when pin is output
// - capture mode change may set the flag once spuriously
// - compare modes test holding register equal to timer count
// - special-event clear does not set timer overflow flag
// - prescaler cleared when off, non-capture mode, or reset
// - writing zero to control register forces compare latch low
module ccmc_top
#(
  parameter bit IS_SECOND_CHANNEL = 1'b0
)
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_reset,
  input  wire logic [3:0]  i_addr,
  input  wire logic [7:0]  i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_channel_pin,
  input  wire logic [15:0] i_timer_one_count,
  input  wire logic        i_adc_enabled,
  input  wire logic        i_flag_clear,
  output logic [7:0]       o_rdata,
  output logic             o_compare_out,
  output logic             o_channel_irq_flag,
  output logic             o_timer_one_clear,
  output logic             o_adc_start,
  output logic [9:0]       o_pwm_duty,
  output logic             o_pwm_mode
);
  import ccmc_pkg::*;

  logic [7:0]  ctrl_ff;
  logic [7:0]  hold_low_ff;
  logic [7:0]  hold_high_ff;
  logic [3:0]  presc_ff;
  logic [3:0]  nxt_presc;
  logic        pin_sync;
  logic        pin_prev_ff;
  logic        match_prev_ff;
  logic [3:0]  mode;
  ccmc_class_t cls;
  logic        rise;
  logic        fall;
  logic        cap_event;
  logic        match_now;
  logic        match_event;
  logic        flag_event;
  logic        ctrl_wr;
  logic        mode_chg_cap;

  // ==================================================
  // pin input synchronisation
  // two-flop pin sync
  ccmc_sync u_sync
  (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_async   (i_channel_pin),
    .o_sync    (pin_sync)
  );

  // ==================================================
  // mode decode
  assign mode    = ctrl_ff[MODE_LSB +: 4];
  assign ctrl_wr = i_wr && (i_addr == ADDR_MODE_CTRL);

  // class from mode field
  always_comb
  begin
    if (mode == MODE_OFF)
      cls = CL_OFF;
    else if (mode[3:2] == 2'b01)
      cls = CL_CAP;
    else if (mode[3:2] == 2'b10)
      cls = CL_CMP;
    else if (mode[3:2] == 2'b11)
      cls = CL_PWM;
    else
      cls = CL_OFF;  // 0001..0011 treated as off
  end

  // ==================================================
  // edge detection
  // pin level watched regardless of direction
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      pin_prev_ff <= 1'b0;
    else
      pin_prev_ff <= pin_sync;
  end

  assign rise = pin_sync && !pin_prev_ff;
  assign fall = !pin_sync && pin_prev_ff;

  // prescaler next value and capture qualification
  always_comb
  begin
    nxt_presc = presc_ff;
    cap_event = 1'b0;
    case (cls)
      CL_CAP:
      begin
        case (mode)
          MODE_CAP_FALL: cap_event = fall;
          MODE_CAP_RISE: cap_event = rise;
          MODE_CAP_4:
          begin
            if (rise)
            begin
              cap_event = (presc_ff[1:0] == PRESC_LAST_4[1:0]);
              nxt_presc = presc_ff + 4'h1;
            end
          end
          MODE_CAP_16:
          begin
            if (rise)
            begin
              cap_event = (presc_ff == PRESC_LAST_16);
              nxt_presc = presc_ff + 4'h1;
            end
          end
          default: cap_event = 1'b0;
        endcase
      end
      default: nxt_presc = 4'h0;
    endcase
  end

  // prescaler counter
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      presc_ff <= 4'h0;
    else
      presc_ff <= nxt_presc;
  end

  // ==================================================
  // compare match
  // holding register equals timer count
  assign match_now   = (cls == CL_CMP) && ({hold_high_ff, hold_low_ff} == i_timer_one_count);
  assign match_event = match_now && !match_prev_ff;  // one action per match

  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      match_prev_ff <= 1'b0;
    else
      match_prev_ff <= match_now;
  end

  // switching capture setting may flag once
  assign mode_chg_cap = ctrl_wr && (cls == CL_CAP) && (i_wdata[3:2] == 2'b01)
                        && (i_wdata[3:0] != mode);

  // match sets flag in all compare modes
  assign flag_event = cap_event || match_event || mode_chg_cap;

  // ==================================================
  // control register
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      ctrl_ff <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_ff <= i_wdata & CTRL_MASK;
  end

  // ==================================================
  // holding register: software writes, capture loads
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      hold_low_ff  <= 8'h00;
      hold_high_ff <= 8'h00;
    end
    else if (cap_event)
    begin
      hold_low_ff  <= i_timer_one_count[7:0];
      hold_high_ff <= i_timer_one_count[15:8];
    end
    else
    begin
      if (i_wr && (i_addr == ADDR_HOLD_LOW))
        hold_low_ff <= i_wdata;
      if (i_wr && (i_addr == ADDR_HOLD_HIGH))
        hold_high_ff <= i_wdata;
    end
  end

  // ==================================================
  // interrupt flag: set wins over clear
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_channel_irq_flag <= 1'b0;
    else if (flag_event)
      o_channel_irq_flag <= 1'b1;
    else if (i_flag_clear || (i_wr && (i_addr == ADDR_FLAG) && !i_wdata[FLAG_BIT]))
      o_channel_irq_flag <= 1'b0;
  end

  // ==================================================
  // compare output latch
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_compare_out <= 1'b0;
    else if (ctrl_wr && (i_wdata == 8'h00))
      o_compare_out <= 1'b0;
    else if (cls == CL_OFF)
      o_compare_out <= 1'b0;
    else if (match_event && (mode == MODE_CMP_SET))
      o_compare_out <= 1'b1;
    else if (match_event && (mode == MODE_CMP_CLR))
      o_compare_out <= 1'b0;
  end

  // ==================================================
  // special event trigger, one-cycle pulses
  // clear timer one and start conversion
  // no overflow flag output is touched here
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_timer_one_clear <= 1'b0;
      o_adc_start       <= 1'b0;
    end
    else
    begin
      o_timer_one_clear <= match_event && (mode == MODE_CMP_SPEV);
      o_adc_start       <= match_event && (mode == MODE_CMP_SPEV)
                           && IS_SECOND_CHANNEL && i_adc_enabled;
    end
  end

  // ==================================================
  // pwm duty export
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
    begin
      o_pwm_duty <= 10'h000;
      o_pwm_mode <= 1'b0;
    end
    else
    begin
      // low byte high part, extra bits low part
      o_pwm_duty <= {hold_low_ff, ctrl_ff[DUTY_LSB +: 2]};
      o_pwm_mode <= (cls == CL_PWM);
    end
  end

  // ==================================================
  // read port, data one cycle after strobe
  always_ff @(posedge i_ref_clk)
  begin
    if (i_reset)
      o_rdata <= 8'h00;
    else if (i_rd)
    begin
      if (i_addr == ADDR_MODE_CTRL)
        o_rdata <= ctrl_ff;
      else if (i_addr == ADDR_HOLD_LOW)
        o_rdata <= hold_low_ff;
      else if (i_addr == ADDR_HOLD_HIGH)
        o_rdata <= hold_high_ff;
      else if (i_addr == ADDR_FLAG)
        o_rdata <= {5'h00, o_channel_irq_flag, 2'h0};
      else if (i_addr == ADDR_STATUS)
        o_rdata <= {presc_ff, cls};
      else
        o_rdata <= 8'h00;
    end
    else
      o_rdata <= 8'h00;
  end
endmodule : ccmc_top

// file: tb/ccmc_pin_src.sv
`timescale 1ns/1ps
// ==========
// far side: signal source on the channel pin
module ccmc_pin_src
(
  input  wire logic i_ref_clk,
  output logic      o_pin
);
  initial o_pin = 1'b0;
  task automatic drive(input logic lvl, input int hold);
    @(posedge i_ref_clk);
    o_pin <= lvl;
    repeat (hold) @(posedge i_ref_clk);
  endtask : drive
endmodule : ccmc_pin_src

// file: tb/ccmc_top_asserts.sv
`timescale 1ns/1ps
module ccmc_top_asserts
  import ccmc_pkg::*;
#(
  parameter bit IS_SECOND_CHANNEL = 1'b0
)
(
  input wire logic       i_ref_clk,
  input wire logic       i_reset,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic       i_channel_pin,
  input wire logic       i_adc_enabled,
  input wire logic       i_flag_clear,
  input wire logic [7:0] o_rdata,
  input wire logic       o_compare_out,
  input wire logic       o_channel_irq_flag,
  input wire logic       o_timer_one_clear,
  input wire logic       o_adc_start,
  input wire logic [9:0] o_pwm_duty,
  input wire logic       o_pwm_mode
);
  logic [3:0] mode_ff;
  logic [3:0] off_cnt_ff;
  logic       ctl_wr;
  logic       st_rd;
  logic       fl_wr0;
  assign ctl_wr = i_wr && (i_addr == ADDR_MODE_CTRL);
  assign st_rd  = i_rd && (i_addr == ADDR_STATUS);
  assign fl_wr0 = i_wr && (i_addr == ADDR_FLAG) && !i_wdata[FLAG_BIT];
  // shadow of the mode field
  always_ff @(posedge i_ref_clk)
  begin
    mode_ff <= i_reset ? MODE_OFF : (ctl_wr ? i_wdata[3:0] : mode_ff);
  end
  // cycles spent in an off mode
  always_ff @(posedge i_ref_clk)
  begin
    off_cnt_ff <= (i_reset || ctl_wr || mode_ff > 4'h3) ? 4'h0 : off_cnt_ff + {3'h0, off_cnt_ff != 4'hf};
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  sequence seq_zero_wr;
    ctl_wr && i_wdata == 8'h00 ##1 !ctl_wr;
  endsequence
  sequence seq_pwm_wr;
    ctl_wr && i_wdata[3:2] == 2'b11 ##1 !ctl_wr;
  endsequence
  sequence seq_rise;
    mode_ff == MODE_CAP_RISE && !ctl_wr && $rose(i_channel_pin) && !o_channel_irq_flag;
  endsequence
  AST_OFF_STATUS: assert property ($past(st_rd) && off_cnt_ff > 4'h3 |-> o_rdata == 8'h01)
    else $error("off status wrong");
  AST_OFF_NO_FLAG: assert property (off_cnt_ff > 4'h5 |-> !$rose(o_channel_irq_flag))
    else $error("flag while off");
  AST_ZERO_WR: assert property (seq_zero_wr |=> !o_compare_out && !o_pwm_mode)
    else $error("zero write not obeyed");
  AST_PWM_DUTY: assert property (seq_pwm_wr |=> o_pwm_mode && o_pwm_duty[1:0] == $past(i_wdata[5:4], 2))
    else $error("pwm setup wrong");
  AST_FLAG_STICKY: assert property ($fell(o_channel_irq_flag) |-> $past(i_flag_clear) || $past(fl_wr0))
    else $error("flag cleared by hardware");
  AST_SPEV_PULSE: assert property (o_timer_one_clear |-> o_channel_irq_flag ##1 !o_timer_one_clear)
    else $error("special event pulse wrong");
  AST_ADC_START: assert property (o_adc_start |-> IS_SECOND_CHANNEL && $past(i_adc_enabled) && o_timer_one_clear)
    else $error("conversion start wrong");
  AST_RISE_CAP: assert property (seq_rise |-> ##[1:4] o_channel_irq_flag)
    else $error("rising edge missed");
  AST_SET_OUT: assert property ($rose(o_compare_out) |-> $past(mode_ff) == MODE_CMP_SET)
    else $error("output set in wrong mode");
endmodule : ccmc_top_asserts
bind ccmc_top ccmc_top_asserts #(.IS_SECOND_CHANNEL(IS_SECOND_CHANNEL)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .i_channel_pin(i_channel_pin), .i_adc_enabled(i_adc_enabled),
  .i_flag_clear(i_flag_clear), .o_rdata(o_rdata), .o_compare_out(o_compare_out),
  .o_channel_irq_flag(o_channel_irq_flag), .o_timer_one_clear(o_timer_one_clear),
  .o_adc_start(o_adc_start), .o_pwm_duty(o_pwm_duty), .o_pwm_mode(o_pwm_mode));

// file: tb/ccmc_top_test.sv
`timescale 1ns/1ps
module ccmc_top_test;
  import ccmc_pkg::*;
  logic        i_ref_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic [3:0]  i_addr = 4'h0;
  logic [7:0]  i_wdata = 8'h00;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_flag_clear = 1'b0;
  logic [15:0] tmr = 16'h0000;
  logic        run = 1'b0;
  logic        pin, cmp, flag, t1clr, adc, pwm, s_clr, s_adc;
  logic [7:0]  rdata;
  logic [9:0]  duty;
  logic [3:0]  cm [6] = '{4'h8, 4'ha, 4'h9, 4'hb, 4'hb, 4'h8};
  logic        adc_en = 1'b1;
  int          fails = 0;
  int          comparisons = 0;
  always #50 i_ref_clk = ~i_ref_clk;
  ccmc_pin_src u_src (.i_ref_clk(i_ref_clk), .o_pin(pin));
  ccmc_top #(.IS_SECOND_CHANNEL(1'b1)) uut (.i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_channel_pin(pin), .i_timer_one_count(tmr),
    .i_adc_enabled(adc_en), .i_flag_clear(i_flag_clear), .o_rdata(rdata), .o_compare_out(cmp),
    .o_channel_irq_flag(flag), .o_timer_one_clear(t1clr), .o_adc_start(adc), .o_pwm_duty(duty),
    .o_pwm_mode(pwm));
  // timer model, cleared by the special event
  always @(posedge i_ref_clk)
  begin
    if (t1clr) tmr <= 16'h0000; else if (run) tmr <= tmr + 16'h0001;
    if (t1clr) s_clr <= 1'b1;
    if (adc) s_adc <= 1'b1;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask : rdc
  // flag cleared after each capture or compare mode change
  task automatic clr;
    @(posedge i_ref_clk) i_flag_clear <= 1'b1;
    @(posedge i_ref_clk) i_flag_clear <= 1'b0;
  endtask : clr
  // two pulses, the second capture overwrites the first
  task automatic t_cap(input logic [3:0] m, input logic [15:0] e);
    wr(ADDR_MODE_CTRL, {4'h0, m}); clr;
    for (int i = 0; i < 2; i++) begin tmr <= 16'h1111 * 16'(i); u_src.drive(1'b1, 5);
      tmr <= 16'h2222 * 16'(i + 1); u_src.drive(1'b0, 5); end
    chk(flag, 1'b1);
    rdc(ADDR_FLAG, 8'h04);
    rdc(ADDR_HOLD_LOW, e[7:0]);
    rdc(ADDR_HOLD_HIGH, e[15:8]);
  endtask : t_cap
  task automatic t_presc(input logic [3:0] m, input int n);
    wr(ADDR_MODE_CTRL, 8'h00); wr(ADDR_MODE_CTRL, {4'h0, m}); clr;
    for (int i = 1; i <= n; i++) begin tmr <= 16'(i); u_src.drive(1'b1, 3); u_src.drive(1'b0, 3);
      chk(flag, i == n); end
    rdc(ADDR_HOLD_LOW, 8'(n));
  endtask : t_presc
  task automatic t_off;
    wr(ADDR_MODE_CTRL, 8'h00); wr(ADDR_FLAG, 8'h00); u_src.drive(1'b1, 5); u_src.drive(1'b0, 8);
    chk(flag, 1'b0);
    rdc(ADDR_STATUS, 8'h01);
  endtask : t_off
  task automatic t_cmp;
    wr(ADDR_HOLD_LOW, 8'h10); wr(ADDR_HOLD_HIGH, 8'h00);
    foreach (cm[i]) begin run <= 1'b0; wr(ADDR_MODE_CTRL, {4'h0, cm[i]}); clr;
      @(posedge i_ref_clk) begin tmr <= 16'h0000; run <= 1'b1; s_clr <= 1'b0; s_adc <= 1'b0; adc_en <= (i != 4); end
      repeat (40) if (flag !== 1'b1) @(negedge i_ref_clk);
      @(negedge i_ref_clk); // pulses reach the timer model one edge later
      chk(flag, 1'b1);
      chk(cmp, i != 2 && i != 3 && i != 4);
      chk({s_clr, s_adc}, {cm[i] == MODE_CMP_SPEV, cm[i] == MODE_CMP_SPEV && i != 4}); end
    run <= 1'b0;
  endtask : t_cmp
  task automatic t_pwm;
    wr(ADDR_MODE_CTRL, 8'h00); @(negedge i_ref_clk) chk(cmp, 1'b0);
    wr(ADDR_HOLD_LOW, 8'ha5); wr(ADDR_MODE_CTRL, 8'h3c);
    repeat (2) @(negedge i_ref_clk);
    chk({pwm, duty}, 11'h697);
    wr(ADDR_MODE_CTRL, 8'hff); rdc(ADDR_MODE_CTRL, 8'h3f);
    rdc(4'hf, 8'h00);
    wr(ADDR_MODE_CTRL, 8'h00); repeat (2) @(negedge i_ref_clk);
    chk(pwm, 1'b0);
  endtask : t_pwm
  task automatic give_verdict;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : give_verdict
  // watchdog
  initial
  begin
    repeat (20000) @(posedge i_ref_clk);
    fails++;
    give_verdict();
  end
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    i_reset <= 1'b0;
    rdc(ADDR_MODE_CTRL, 8'h00);
    t_cap(MODE_CAP_RISE, 16'h1111);
    t_cap(MODE_CAP_FALL, 16'h4444);
    t_presc(MODE_CAP_4, 4);
    t_presc(MODE_CAP_16, 16);
    t_off();
    t_cmp();
    t_pwm();
    give_verdict();
  end
endmodule : ccmc_top_test
